// ### rtl/host_irq_and_message_fifo_regs.v
`timescale 1ns/1ps
`include "host_irq_fifo_consts.vh"

//
// Contract
// (R1) Diagnostic address register holds 32-bit internal-bus location for diagnostic data.
// (R2) Any host write to flags register clears the system doorbell flag, bit 0.
// (R3) Each function has its own interrupt flags register.
// (R4) Bit 31 is one while a host doorbell waits for the processor.
// (R5) Bit 3 is one whenever the reply post queue is not empty.
// (R6) Interrupt requested when reply or doorbell flag set and its mask clear.
// (R7) Processor doorbell write sets flag bit 0.
// (R8) Mask bit 3 blocks reply interrupts; flag still reports.
// (R9) Mask bit 0 blocks doorbell interrupts.
// (R10) Routing 00 both pins, 01/11 primary only, 10 alternate only.
// (R11) With message-signalled interrupts enabled neither pin is asserted.
// (R12) Each function has its own mask and routing register.
// (R13) Request port read pops free frame pointer, or returns the empty value.
// (R14) Host write to request port posts a request entry.
// (R15) Request port is one register shared by both functions.
// (R16) Reply port read pops posted reply pointer, or returns the empty value.
// (R17) Host write to reply port returns a free reply entry.
// (R18) Each function has its own reply port.
// (R19) Host doorbell write interrupts processor and shows the written word.
// (R20) Per-function request is registered OR of flags gated by clear masks.
module host_irq_and_message_fifo_regs (
    input  wire        mclk_i,                // Clock, 200 MHz
    input  wire        reset_i,               // Synchronous reset, active high
    input  wire        host_req_i,            // Host access, held until ack
    input  wire        host_wr_i,             // 1 write, 0 read
    input  wire        host_func_i,           // Addressed function
    input  wire [7:0]  host_addr_i,           // Byte offset
    input  wire [31:0] host_wdata_i,          // Write data
    output wire        host_ack_o,            // Access done, one-cycle pulse
    output wire [31:0] host_rdata_o,          // Read data, valid with ack
    input  wire [1:0]  msi_en_i,              // Per-function MSI enable
    output wire [1:0]  primary_irq_pin_n_o,   // Primary pins, active low
    output wire [1:0]  alternate_irq_pin_n_o, // Alternate pins, active low
    input  wire [1:0]  iop_db_wr_i,           // Processor doorbell write
    input  wire [63:0] iop_db_wdata_i,        // Processor doorbell words
    input  wire [1:0]  iop_db_clr_i,          // Processor clears its request
    input  wire [1:0]  iop_db_mask_i,         // Processor-side doorbell mask
    output wire [63:0] iop_db_value_o,        // Host doorbell words
    output wire [1:0]  iop_db_irq_o,          // Processor doorbell interrupt
    input  wire        iop_rqf_valid_i,       // Free request pointer offered
    input  wire [31:0] iop_rqf_data_i,        // Free request pointer
    output wire        iop_rqf_ready_o,       // Free request room
    output wire        iop_rqp_valid_o,       // Posted request present
    output wire [31:0] iop_rqp_data_o,        // Posted request pointer
    input  wire        iop_rqp_ready_i,       // Posted request taken
    input  wire [1:0]  iop_rpp_valid_i,       // Reply post offered
    input  wire [63:0] iop_rpp_data_i,        // Reply post pointers
    output wire [1:0]  iop_rpp_ready_o,       // Reply post room
    output wire [1:0]  iop_rpf_valid_o,       // Free reply present
    output wire [63:0] iop_rpf_data_o,        // Free reply pointers
    input  wire [1:0]  iop_rpf_ready_i,       // Free reply taken
    output wire [31:0] diag_addr_o            // Diagnostic address
);

    // ****************************************************************
    // Routing decode
    // ****************************************************************

    // Returns {alternate, primary} request for one function
    function [1:0] route_pins;
        input [1:0] mode;
        input       req;
        input       msi;
        begin
            if (!req || msi) begin
                route_pins = 2'h0;                               // [R11]
            end else if (mode == `ROUTE_BOTH) begin
                route_pins = 2'h3;                               // [R10]
            end else if (mode == `ROUTE_ALT_ONLY) begin
                route_pins = 2'h2;                               // [R10]
            end else begin
                route_pins = 2'h1;                               // [R10]
            end
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg        ack_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg [31:0] diag_addr_q;
    reg [63:0] host_db_q;
    reg [63:0] iop_db_q;
    reg [1:0]  iop_pend_q;
    reg [1:0]  iop_irq_q;
    reg [1:0]  sys_db_q;
    reg [1:0]  dmask_q;
    reg [1:0]  rmask_q;
    reg [3:0]  route_q;
    reg [1:0]  pri_n_q;
    reg [1:0]  alt_n_q;
    integer    f;

    wire        sel_db;
    wire        sel_diag;
    wire        sel_flags;
    wire        sel_mask;
    wire        sel_rq;
    wire        sel_rp;
    wire        stall;
    wire        take;
    wire        take_wr;
    wire        take_rd;
    wire        rqf_valid;
    wire [31:0] rqf_data;
    wire        rqp_ready;
    wire [1:0]  rpp_valid;
    wire [63:0] rpp_data;
    wire [1:0]  rpf_ready;
    wire [1:0]  rpp_pop;
    wire [1:0]  rpf_push;
    wire [3:0]  pins;
    wire [1:0]  fn_req;

    // ****************************************************************
    // Host access decode and handshake
    // ****************************************************************

    // Address decode
    assign sel_db    = (host_addr_i == `OFS_DOORBELL);
    assign sel_diag  = (host_addr_i == `OFS_DIAG_ADDR);
    assign sel_flags = (host_addr_i == `OFS_IRQ_FLAGS);
    assign sel_mask  = (host_addr_i == `OFS_IRQ_MASK_ROUTE);
    assign sel_rq    = (host_addr_i == `OFS_REQUEST_QUEUE);
    assign sel_rp    = (host_addr_i == `OFS_REPLY_QUEUE);

    // Queue writes wait while the target buffer is full
    assign stall   = host_wr_i & ((sel_rq & ~rqp_ready) |
                                  (sel_rp & ~rpf_ready[host_func_i]));
    assign take    = host_req_i & ~ack_q & ~stall;
    assign take_wr = take & host_wr_i;
    assign take_rd = take & ~host_wr_i;

    // Pops and pushes steered by function
    assign rpp_pop  = {take_rd & sel_rp & host_func_i,
                       take_rd & sel_rp & ~host_func_i};          // [R16]
    assign rpf_push = {take_wr & sel_rp & host_func_i,
                       take_wr & sel_rp & ~host_func_i};          // [R17]

    // Read data mux
    always @* begin
        rdata_d = `RESET_WORD;
        case (host_addr_i)
            `OFS_DOORBELL: begin
                rdata_d = iop_db_q[32*host_func_i +: 32];
            end
            `OFS_DIAG_ADDR: begin
                rdata_d = diag_addr_q;                             // [R1]
            end
            `OFS_IRQ_FLAGS: begin
                rdata_d[`FLAG_IOP_DOORBELL] = iop_pend_q[host_func_i]; // [R4]
                rdata_d[`FLAG_REPLY]        = rpp_valid[host_func_i];  // [R5]
                rdata_d[`FLAG_SYS_DOORBELL] = sys_db_q[host_func_i];   // [R3]
            end
            `OFS_IRQ_MASK_ROUTE: begin
                rdata_d[`ROUTE_HI:`ROUTE_LO] = route_q[2*host_func_i +: 2];
                rdata_d[`MASK_REPLY]         = rmask_q[host_func_i];   // [R12]
                rdata_d[`MASK_DOORBELL]      = dmask_q[host_func_i];
            end
            `OFS_REQUEST_QUEUE: begin
                rdata_d = rqf_valid ? rqf_data : `QUEUE_EMPTY_VALUE;   // [R13]
            end
            `OFS_REPLY_QUEUE: begin
                rdata_d = rpp_valid[host_func_i] ?
                          rpp_data[32*host_func_i +: 32] :
                          `QUEUE_EMPTY_VALUE;                          // [R16]
            end
            default: begin
                rdata_d = `RESET_WORD;
            end
        endcase
    end

    // Ack pulse and captured read data
    always @(posedge mclk_i) begin
        if (reset_i) begin
            ack_q   <= 1'b0;
            rdata_q <= `RESET_WORD;
        end else begin
            ack_q <= take;
            if (take_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // ****************************************************************
    // Doorbells, flags, masks and diagnostic address
    // ****************************************************************

    // Register writes and hardware-set flags; sets win over clears
    always @(posedge mclk_i) begin
        if (reset_i) begin
            diag_addr_q <= `RESET_WORD;
            host_db_q   <= {2{`RESET_WORD}};
            iop_db_q    <= {2{`RESET_WORD}};
            iop_pend_q  <= 2'h0;
            sys_db_q    <= 2'h0;
            dmask_q     <= {2{`RESET_MASK_BIT}};
            rmask_q     <= {2{`RESET_MASK_BIT}};
            route_q     <= {2{`RESET_ROUTE}};
        end else begin
            if (take_wr && sel_diag) begin
                diag_addr_q <= host_wdata_i;                       // [R1]
            end
            for (f = 0; f < 2; f = f + 1) begin
                // Host doorbell to the processor
                if (iop_db_clr_i[f]) begin
                    iop_pend_q[f] <= 1'b0;                         // [R4]
                end
                if (take_wr && sel_db && host_func_i == f) begin
                    host_db_q[32*f +: 32] <= host_wdata_i;         // [R19]
                    iop_pend_q[f]         <= 1'b1;                 // [R4]
                end
                // Processor doorbell to the host
                if (take_wr && sel_flags && host_func_i == f) begin
                    sys_db_q[f] <= 1'b0;                           // [R2]
                end
                if (iop_db_wr_i[f]) begin
                    iop_db_q[32*f +: 32] <= iop_db_wdata_i[32*f +: 32];
                    sys_db_q[f]          <= 1'b1;                  // [R7]
                end
                // Per-function mask and routing
                if (take_wr && sel_mask && host_func_i == f) begin
                    route_q[2*f +: 2] <= host_wdata_i[`ROUTE_HI:`ROUTE_LO]; // [R12]
                    rmask_q[f]        <= host_wdata_i[`MASK_REPLY];
                    dmask_q[f]        <= host_wdata_i[`MASK_DOORBELL];
                end
            end
        end
    end

    // ****************************************************************
    // Interrupt requests and pins
    // ****************************************************************

    // Requests gated by clear masks, routed as {alt, pri} per function
    assign fn_req    = (rpp_valid & ~rmask_q) | (sys_db_q & ~dmask_q); // [R6] [R8] [R9] [R20]
    assign pins[1:0] = route_pins(route_q[1:0], fn_req[0], msi_en_i[0]); // [R11]
    assign pins[3:2] = route_pins(route_q[3:2], fn_req[1], msi_en_i[1]); // [R11]

    // Registered pins and processor doorbell interrupt
    always @(posedge mclk_i) begin
        if (reset_i) begin
            pri_n_q   <= {2{`RESET_PIN_N}};
            alt_n_q   <= {2{`RESET_PIN_N}};
            iop_irq_q <= 2'h0;
        end else begin
            pri_n_q   <= ~{pins[2], pins[0]}; // [R10]
            alt_n_q   <= ~{pins[3], pins[1]}; // [R10]
            iop_irq_q <= iop_pend_q & ~iop_db_mask_i; // [R19]
        end
    end

    // ****************************************************************
    // Message frame pointer queues
    // ****************************************************************

    // Shared free request queue, filled by the processor
    two_entry_buffer u_req_free (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .in_valid_i  (iop_rqf_valid_i),
        .in_data_i   (iop_rqf_data_i),
        .in_ready_o  (iop_rqf_ready_o),
        .out_valid_o (rqf_valid),
        .out_data_o  (rqf_data),
        .out_ready_i (take_rd & sel_rq)                            // [R13] [R15]
    );

    // Shared posted request queue, drained by the processor
    two_entry_buffer u_req_post (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .in_valid_i  (take_wr & sel_rq),                           // [R14] [R15]
        .in_data_i   (host_wdata_i),
        .in_ready_o  (rqp_ready),
        .out_valid_o (iop_rqp_valid_o),
        .out_data_o  (iop_rqp_data_o),
        .out_ready_i (iop_rqp_ready_i)
    );

    // One reply port pair per function
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_reply
            two_entry_buffer u_reply_post (
                .mclk_i      (mclk_i),
                .reset_i     (reset_i),
                .in_valid_i  (iop_rpp_valid_i[g]),
                .in_data_i   (iop_rpp_data_i[32*g +: 32]),
                .in_ready_o  (iop_rpp_ready_o[g]),
                .out_valid_o (rpp_valid[g]),
                .out_data_o  (rpp_data[32*g +: 32]),
                .out_ready_i (rpp_pop[g])                          // [R18]
            );
            two_entry_buffer u_reply_free (
                .mclk_i      (mclk_i),
                .reset_i     (reset_i),
                .in_valid_i  (rpf_push[g]),                        // [R18]
                .in_data_i   (host_wdata_i),
                .in_ready_o  (rpf_ready[g]),
                .out_valid_o (iop_rpf_valid_o[g]),
                .out_data_o  (iop_rpf_data_o[32*g +: 32]),
                .out_ready_i (iop_rpf_ready_i[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign host_ack_o            = ack_q;
    assign host_rdata_o          = rdata_q;
    assign primary_irq_pin_n_o   = pri_n_q;
    assign alternate_irq_pin_n_o = alt_n_q;
    assign iop_db_value_o        = host_db_q;
    assign iop_db_irq_o          = iop_irq_q;
    assign diag_addr_o           = diag_addr_q;

endmodule // host_irq_and_message_fifo_regs

// ### rtl/host_irq_fifo_consts.vh
`ifndef HOST_IRQ_FIFO_CONSTS_VH
`define HOST_IRQ_FIFO_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_DOORBELL        8'h00
`define OFS_DIAG_ADDR       8'h14
`define OFS_IRQ_FLAGS       8'h30
`define OFS_IRQ_MASK_ROUTE  8'h34
`define OFS_REQUEST_QUEUE   8'h40
`define OFS_REPLY_QUEUE     8'h44

// ****************************************************************
// Field positions
// ****************************************************************
`define FLAG_SYS_DOORBELL   0
`define FLAG_REPLY          3
`define FLAG_IOP_DOORBELL   31
`define MASK_DOORBELL       0
`define MASK_REPLY          3
`define ROUTE_LO            8
`define ROUTE_HI            9

// ****************************************************************
// Routing encodings and values
// ****************************************************************
`define ROUTE_BOTH          2'h0
`define ROUTE_ALT_ONLY      2'h2
`define QUEUE_EMPTY_VALUE   32'h0FFFFFFF
`define RESET_WORD          32'h00000000
`define RESET_ROUTE         2'h0
`define RESET_MASK_BIT      1'h0
`define RESET_PIN_N         1'h1

`endif

// ### rtl/two_entry_buffer.v
`timescale 1ns/1ps
`include "host_irq_fifo_consts.vh"

// ****************************************************************
// Two-entry buffer, head always in slot 0
// ****************************************************************
module two_entry_buffer (
    input  wire        mclk_i,      // Clock
    input  wire        reset_i,     // Synchronous reset, active high
    input  wire        in_valid_i,  // Word offered
    input  wire [31:0] in_data_i,   // Word offered
    output wire        in_ready_o,  // Room for a word
    output wire        out_valid_o, // Head word present
    output wire [31:0] out_data_o,  // Head word
    input  wire        out_ready_i  // Head word taken
);

    reg [31:0] mem_q [0:1];
    reg        v0_q;
    reg        v1_q;
    wire       push;
    wire       pop;

    // Handshakes and flop-driven outputs
    assign in_ready_o  = ~v1_q;
    assign out_valid_o = v0_q;
    assign out_data_o  = mem_q[0];
    assign push        = in_valid_i & ~v1_q;
    assign pop         = out_ready_i & v0_q;

    // Shift storage towards slot 0
    always @(posedge mclk_i) begin
        if (reset_i) begin
            v0_q     <= 1'b0;
            v1_q     <= 1'b0;
            mem_q[0] <= `RESET_WORD;
            mem_q[1] <= `RESET_WORD;
        end else if (push && pop) begin
            if (v1_q) begin
                mem_q[0] <= mem_q[1];
                mem_q[1] <= in_data_i;
            end else begin
                mem_q[0] <= in_data_i;
            end
        end else if (pop) begin
            mem_q[0] <= mem_q[1];
            v0_q     <= v1_q;
            v1_q     <= 1'b0;
        end else if (push) begin
            if (v0_q) begin
                mem_q[1] <= in_data_i;
                v1_q     <= 1'b1;
            end else begin
                mem_q[0] <= in_data_i;
                v0_q     <= 1'b1;
            end
        end
    end

endmodule // two_entry_buffer

// ### tb/host_irq_props_properties.sv
`timescale 1ns/1ps

// ****************************************
// Host port properties
// ****************************************
module host_irq_props (
    input wire        mclk_i, // Clock
    input wire        reset_i, // Sync reset
    input wire        host_req_i, // Host access
    input wire        host_wr_i, // Write
    input wire        host_func_i, // Function
    input wire [7:0]  host_addr_i, // Offset
    input wire [31:0] host_wdata_i, // Write data
    input wire        host_ack_o, // Done pulse
    input wire [31:0] host_rdata_o, // Read data
    input wire [1:0]  msi_en_i, // MSI enables
    input wire [1:0]  primary_irq_pin_n_o, // Primary pins
    input wire [1:0]  alternate_irq_pin_n_o, // Alternate pins
    input wire [1:0]  iop_db_clr_i, // Doorbell clear
    input wire [1:0]  iop_db_mask_i, // Doorbell mask
    input wire [63:0] iop_db_value_o, // Host doorbell words
    input wire [1:0]  iop_db_irq_o, // Processor irq
    input wire        iop_rqp_valid_o, // Posted request
    input wire [1:0]  iop_rpf_valid_o, // Free reply
    input wire [31:0] diag_addr_o // Diag address
);
    // Host write offered on this edge, ignoring a queue-full stall
    wire wr_take = host_req_i & host_wr_i & ~host_ack_o;

    // One clock domain
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_ack_once: assert property (
        host_ack_o |=> !host_ack_o) else $error("ack too long");
    a_read_ack: assert property (
        host_req_i && !host_wr_i && !host_ack_o |=> host_ack_o) else $error("read not acked");
    a_rdata_hold: assert property (
        !(host_ack_o && !$past(host_wr_i)) |-> $stable(host_rdata_o)) else $error("rdata moved");
    a_diag_write: assert property (
        wr_take && host_addr_i == 8'h14 |=> diag_addr_o == $past(host_wdata_i))
        else $error("diag wrong");
    a_db_value: assert property (
        wr_take && host_addr_i == 8'h00 && !host_func_i
        |=> iop_db_value_o[31:0] == $past(host_wdata_i)) else $error("db word wrong");
    a_db_irq: assert property (
        wr_take && host_addr_i == 8'h00 && !host_func_i && !iop_db_mask_i[0]
        ##1 (!iop_db_mask_i[0] && !iop_db_clr_i[0]) [*2] |-> iop_db_irq_o[0])
        else $error("db irq missing");
    a_post_valid: assert property (
        host_ack_o && $past(host_wr_i) && $past(host_addr_i) == 8'h40 |-> iop_rqp_valid_o)
        else $error("no post");
    a_free_reply: assert property (
        host_ack_o && $past(host_wr_i) && $past(host_addr_i) == 8'h44 && !$past(host_func_i)
        |-> iop_rpf_valid_o[0]) else $error("no free reply");
    a_msi_quiet: assert property (
        msi_en_i[0] && $past(msi_en_i[0])
        |-> primary_irq_pin_n_o[0] && alternate_irq_pin_n_o[0]) else $error("pin under msi");
endmodule // host_irq_props

bind host_irq_and_message_fifo_regs host_irq_props i_host_irq_props (
    .mclk_i, .reset_i, .host_req_i, .host_wr_i, .host_func_i, .host_addr_i, .host_wdata_i,
    .host_ack_o, .host_rdata_o, .msi_en_i, .primary_irq_pin_n_o, .alternate_irq_pin_n_o,
    .iop_db_clr_i, .iop_db_mask_i, .iop_db_value_o, .iop_db_irq_o, .iop_rqp_valid_o,
    .iop_rpf_valid_o, .diag_addr_o);

// ### tb/host_master_model.sv
`timescale 1ns/1ps

// ****************************************
// Host bus master on the register port
// ****************************************
module host_master_model (
    input  wire logic        mclk_i, // Clock
    input  wire logic        ack_i, // Access done
    input  wire logic [31:0] rdata_i, // Read data
    output logic             req_o   = 1'h0, // Access request
    output logic             wr_o    = 1'h0, // Write
    output logic             func_o  = 1'h0, // Function
    output logic [7:0]       addr_o  = 8'h00, // Offset
    output logic [31:0]      wdata_o = 32'h0 // Write data
);
    // Drive after an edge, hold until ack is sampled, then release
    task automatic access(input logic wr, fn, input logic [7:0] a, input logic [31:0] d,
                          input int lim, output logic [31:0] q, output logic lost);
        lost = 1'h1;
        q = 32'h0;
        req_o = 1'h1;
        wr_o = wr;
        func_o = fn;
        addr_o = a;
        wdata_o = d;
        for (int n = 0; n < lim && lost; n++) begin
            @(posedge mclk_i);
            #1;
            if (ack_i === 1'h1) begin
                lost = 1'h0;
                q = rdata_i;
            end
        end
        if (!lost) @(posedge mclk_i);
        #1;
        req_o = 1'h0;
        addr_o = ~a;
        wdata_o = ~d;
        @(posedge mclk_i);
        #1;
    endtask
endmodule // host_master_model

// ### tb/tb_host_irq_and_message_fifo_regs.sv
`timescale 1ns/1ps

// ****************************************
// Host interrupt and queue register bench
// ****************************************
module tb_host_irq_and_message_fifo_regs;
    logic        mclk_i = 1'h0, reset_i = 1'h1, iop_rqf_valid_i = 1'h0, iop_rqp_ready_i = 1'h0;
    logic        host_req_i, host_wr_i, host_func_i, host_ack_o, lost;
    logic        iop_rqf_ready_o, iop_rqp_valid_o;
    logic [1:0]  msi_en_i = 2'h0, iop_db_wr_i = 2'h0, iop_db_clr_i = 2'h0, iop_db_mask_i = 2'h0;
    logic [1:0]  iop_rpp_valid_i = 2'h0, iop_rpf_ready_i = 2'h0;
    logic [1:0]  primary_irq_pin_n_o, alternate_irq_pin_n_o, iop_db_irq_o;
    logic [1:0]  iop_rpp_ready_o, iop_rpf_valid_o;
    logic [7:0]  host_addr_i;
    logic [31:0] iop_rqf_data_i = 32'h0;
    logic [31:0] host_wdata_i, host_rdata_o, iop_rqp_data_o, diag_addr_o, rd, w;
    logic [63:0] iop_db_wdata_i = 64'h0, iop_rpp_data_i = 64'h0, iop_db_value_o, iop_rpf_data_o;
    integer      seed = 4, bad_count = 0, samples_checked = 0, r;

    // Clock, 5 ns period
    always #2.5 mclk_i = ~mclk_i;

    // Block and host master
    host_irq_and_message_fifo_regs i_host_irq_and_message_fifo_regs (
        .mclk_i, .reset_i, .host_req_i, .host_wr_i, .host_func_i, .host_addr_i, .host_wdata_i,
        .host_ack_o, .host_rdata_o, .msi_en_i, .primary_irq_pin_n_o, .alternate_irq_pin_n_o,
        .iop_db_wr_i, .iop_db_wdata_i, .iop_db_clr_i, .iop_db_mask_i, .iop_db_value_o,
        .iop_db_irq_o, .iop_rqf_valid_i, .iop_rqf_data_i, .iop_rqf_ready_o, .iop_rqp_valid_o,
        .iop_rqp_data_o, .iop_rqp_ready_i, .iop_rpp_valid_i, .iop_rpp_data_i, .iop_rpp_ready_o,
        .iop_rpf_valid_o, .iop_rpf_data_o, .iop_rpf_ready_i, .diag_addr_o);
    host_master_model i_host_master_model (.mclk_i, .ack_i(host_ack_o), .rdata_i(host_rdata_o),
        .req_o(host_req_i), .wr_o(host_wr_i), .func_o(host_func_i), .addr_o(host_addr_i),
        .wdata_o(host_wdata_i));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task report_and_stop();
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task step();
        @(posedge mclk_i);
        #1;
    endtask

    task automatic hx(input logic wr, fn, input logic [7:0] a, input logic [31:0] d, st);
        i_host_master_model.access(wr, fn, a, d, st ? 5 : 40, rd, lost);
        chk(32'(lost), 32'(st[0]));
        if (lost && !st[0]) report_and_stop();
    endtask

    task automatic put(input logic fn, input logic [7:0] a, input logic [31:0] d);
        hx(1'h1, fn, a, d, 32'h0);
    endtask

    task automatic get(input logic fn, input logic [7:0] a, input logic [31:0] e);
        hx(1'h0, fn, a, 32'h0, 32'h0);
        chk(rd, e);
    endtask

    // Pins as {alt1, alt0, pri1, pri0}
    task automatic pins(input logic [3:0] e);
        repeat (3) step();
        chk(32'({alternate_irq_pin_n_o, primary_irq_pin_n_o}), 32'(e));
    endtask

    // Expected pins, reply pending on f0
    function automatic logic [3:0] epin(input logic [1:0] m);
        return {1'h1, m[0], 1'h1, m == 2'h2};
    endfunction

    task automatic push_rqf(input logic [31:0] d);
        iop_rqf_valid_i = 1'h1;
        for (int i = 0; i < 2; i++) begin
            iop_rqf_data_i = d + i;
            step();
        end
        iop_rqf_valid_i = 1'h0;
        iop_rqf_data_i = ~d;
    endtask

    task automatic push_rpp(input int f, input logic [31:0] d);
        iop_rpp_valid_i[f] = 1'h1;
        iop_rpp_data_i[32*f +: 32] = d;
        step();
        iop_rpp_valid_i[f] = 1'h0;
        iop_rpp_data_i[32*f +: 32] = ~d;
    endtask

    task automatic drain_rqp(input logic [31:0] d);
        iop_rqp_ready_i = 1'h1;
        for (int i = 0; i < 2; i++) begin
            chk(32'(iop_rqp_valid_o), 32'h1);
            chk(iop_rqp_data_o, i ? ~d : d);
            step();
        end
        iop_rqp_ready_i = 1'h0;
        chk(32'(iop_rqp_valid_o), 32'h0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) step();
        reset_i = 1'h0;
        for (r = 0; r < 4; r++) get(r[0], r[1] ? 8'h34 : 8'h30, 32'h0);
        pins(4'hF);
        w = $random(seed);
        put(1'h1, 8'h14, w);
        get(1'h0, 8'h14, w);
        chk(diag_addr_o, w);
        get(1'h0, 8'h50, 32'h0);
        get(1'h0, 8'h40, 32'h0FFFFFFF);
        push_rqf(w);
        chk(32'({iop_rqf_ready_o, iop_rpp_ready_o}), 32'h3);
        get(1'h1, 8'h40, w);
        get(1'h0, 8'h40, w + 32'h1);
        get(1'h1, 8'h40, 32'h0FFFFFFF);
        w = $random(seed);
        put(1'h0, 8'h40, w);
        put(1'h1, 8'h40, ~w);
        hx(1'h1, 1'h0, 8'h40, w, 32'h1);
        drain_rqp(w);
        w = $random(seed);
        push_rpp(1, w);
        get(1'h1, 8'h30, 32'h8);
        get(1'h0, 8'h30, 32'h0);
        get(1'h0, 8'h44, 32'h0FFFFFFF);
        get(1'h1, 8'h44, w);
        get(1'h1, 8'h30, 32'h0);
        put(1'h0, 8'h44, ~w);
        chk(32'(iop_rpf_valid_o[0]), 32'h1);
        chk(iop_rpf_data_o[31:0], ~w);
        push_rpp(0, w);
        for (r = 0; r < 4; r++) begin
            put(1'h0, 8'h34, {22'h0, r[1:0], 8'h0});
            pins(epin(r[1:0]));
        end
        put(1'h0, 8'h34, 32'h8);
        pins(4'hF);
        get(1'h0, 8'h30, 32'h8);
        put(1'h0, 8'h34, 32'h0);
        msi_en_i = 2'h1;
        pins(4'hF);
        msi_en_i = 2'h0;
        get(1'h0, 8'h44, w);
        iop_db_wdata_i[31:0] = ~w;
        iop_db_wr_i = 2'h1;
        step();
        iop_db_wr_i = 2'h0;
        get(1'h0, 8'h30, 32'h1);
        pins(4'hA);
        get(1'h0, 8'h00, ~w);
        put(1'h0, 8'h34, 32'h1);
        pins(4'hF);
        put(1'h0, 8'h30, w);
        get(1'h0, 8'h30, 32'h0);
        put(1'h0, 8'h00, w);
        chk(iop_db_value_o[31:0], w);
        get(1'h0, 8'h30, 32'h80000000);
        chk(32'(iop_db_irq_o), 32'h1);
        iop_db_clr_i = 2'h1;
        step();
        iop_db_clr_i = 2'h0;
        get(1'h0, 8'h30, 32'h0);
        report_and_stop();
    end
endmodule // tb_host_irq_and_message_fifo_regs
